//--- hdl/cfu_params.svh
// Constants of the card firmware update sequencer
`ifndef CFU_PARAMS_SVH
`define CFU_PARAMS_SVH
// Firmware image length in bytes, and index of its last byte
`define CFU_IMG_BYTES 7'h40
`define CFU_IMG_LAST 7'h3F
// Index of the last parameter file byte
`define CFU_PAR_LAST 7'h0F
// Top value of the progress display
`define CFU_PCT_TOP 7'h64
// File selectors sent to the card
`define CFU_FILE_NONE 2'h0
`define CFU_FILE_IMG 2'h1
`define CFU_FILE_PAR 2'h2
// Number of synchronised pin inputs
`define CFU_SYNC_W 9
// Positions in the synchronised input vector
`define CFU_IN_KEY_A 0
`define CFU_IN_KEY_B 1
`define CFU_IN_AUX 2
`define CFU_IN_PRES 3
`define CFU_IN_ERR 4
`define CFU_IN_CCLK 5
`define CFU_IN_CDAT 6
`define CFU_IN_NOFILE 7
`define CFU_IN_SD 8
`endif

//--- hdl/cfu_pkg.sv
// Types of the card firmware update sequencer
`include "cfu_params.svh"
package cfu_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    S_POR, S_RUN, S_MON, S_COPY, S_ERASE, S_PROG, S_PAR, S_CCC
  } cfu_state_t;
  // What the front display shows
  typedef enum logic [1:0] {
    DISP_BLANK, DISP_DASH, DISP_CCC, DISP_NUM
  } cfu_dmode_t;
  typedef struct packed {
    cfu_dmode_t mode;
    logic [6:0] value;
  } cfu_disp_t;
  // Internal program memory port
  typedef struct packed {
    logic erase;
    logic we;
    logic [5:0] addr;
    logic [7:0] data;
  } cfu_pm_t;
  // Request towards the card
  typedef struct packed {
    logic req;
    logic [1:0] file;
    logic sd_mode;
  } cfu_card_t;
  // Whole state of the sequencer
  typedef struct packed {
    cfu_state_t st;
    cfu_state_t ret;
    cfu_disp_t disp;
    cfu_pm_t pm;
    cfu_card_t card;
    logic fw_run;
    logic par_stb;
    logic [7:0] par_byte;
    logic [6:0] cnt;
    logic [7:0] shreg;
    logic [2:0] bitn;
    logic clk_prev;
    logic keys_rel;
    logic busy;
    logic [63:0][7:0] mem;
  } cfu_st_t;
  // State of the input synchroniser
  typedef struct packed {
    logic [`CFU_SYNC_W-1:0] ff1;
    logic [`CFU_SYNC_W-1:0] ff2;
    logic [`CFU_SYNC_W-1:0] ff3;
    logic [`CFU_SYNC_W-1:0] q;
  } cfu_sync_t;
endpackage

//--- hdl/cfu_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "cfu_params.svh"
module cfu_sync (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [`CFU_SYNC_W-1:0] i_pins,
  output logic [`CFU_SYNC_W-1:0] o_q
);
  cfu_pkg::cfu_sync_t s_r;
  cfu_pkg::cfu_sync_t s_nxt;

  // ==========================================
  // Shift chain; output moves only when ff2 and ff3 agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.ff1 = i_pins;
    s_nxt.ff2 = s_r.ff1;
    s_nxt.ff3 = s_r.ff2;
    for (int i = 0; i < `CFU_SYNC_W; i++) begin
      if (s_r.ff2[i] == s_r.ff3[i]) begin
        s_nxt.q[i] = s_r.ff3[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_q = s_r.q;
endmodule

//--- hdl/cfu_top.sv
// Card firmware update sequencer, top level
// How it works
// - Accept both MMC and SD cards
// - Keypad or setup software may start transfers
// - Both keys at power-up: monitor, dash
// - Card failure in monitor shows CCC
// - Halted command resumes after card reinserted
// - Second double key press starts update
// - Copy phase counts display up 0..100
// - Erase phase holds display at 100
// - Program phase counts display down 100..0
// - New firmware starts after programming
// - Parameter file loaded automatically on restart
`timescale 1ns/1ps
`include "cfu_params.svh"
module cfu_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_key_a,
  input wire logic i_key_b,
  input wire logic i_aux_ok,
  input wire logic i_sw_start,
  input wire logic i_card_present,
  input wire logic i_card_err,
  input wire logic i_card_clk,
  input wire logic i_card_dat,
  input wire logic i_card_nofile,
  input wire logic i_card_sd,
  input wire logic i_pm_done,
  output cfu_pkg::cfu_disp_t o_disp,
  output cfu_pkg::cfu_pm_t o_pm,
  output cfu_pkg::cfu_card_t o_card,
  output logic o_fw_run,
  output logic o_par_stb,
  output logic [7:0] o_par_byte
);
  cfu_pkg::cfu_st_t st_r;
  cfu_pkg::cfu_st_t st_nxt;
  logic [`CFU_SYNC_W-1:0] pins;
  logic [`CFU_SYNC_W-1:0] s;
  logic both_keys;
  logic card_bad;
  logic bit_edge;
  logic [7:0] new_byte;

  // ==========================================
  // Input synchronisation
  assign pins = {i_card_sd, i_card_nofile, i_card_dat, i_card_clk,
                 i_card_err, i_card_present, i_aux_ok, i_key_b, i_key_a};

  cfu_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pins(pins),
    .o_q(s)
  );

  // Decoded conditions
  assign both_keys = s[`CFU_IN_KEY_A] & s[`CFU_IN_KEY_B];
  assign card_bad = !s[`CFU_IN_PRES] | s[`CFU_IN_ERR];
  assign bit_edge = s[`CFU_IN_CCLK] & !st_r.clk_prev;
  assign new_byte = {st_r.shreg[6:0], s[`CFU_IN_CDAT]};

  // ==========================================
  // Progress in percent of the image
  function automatic logic [6:0] pct(input logic [6:0] n);
    logic [13:0] prod;
    prod = {7'h00, n} * {7'h00, `CFU_PCT_TOP};
    pct = 7'(prod / {7'h00, `CFU_IMG_BYTES});
  endfunction

  // ==========================================
  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.clk_prev = s[`CFU_IN_CCLK];
    st_nxt.par_stb = 1'b0;
    st_nxt.pm.we = 1'b0;
    unique case (st_r.st)
      cfu_pkg::S_POR: begin
        st_nxt.disp.mode = cfu_pkg::DISP_BLANK;
        if (s[`CFU_IN_AUX]) begin
          if (both_keys) begin
            st_nxt.st = cfu_pkg::S_MON;
            st_nxt.keys_rel = 1'b0;
          end else begin
            st_nxt.fw_run = 1'b1;
            st_nxt.st = cfu_pkg::S_PAR;
            st_nxt.cnt = 7'h00;
            st_nxt.bitn = 3'h0;
          end
        end
      end
      cfu_pkg::S_MON: begin
        st_nxt.disp.mode = cfu_pkg::DISP_DASH;
        if (!s[`CFU_IN_KEY_A] && !s[`CFU_IN_KEY_B]) begin
          st_nxt.keys_rel = 1'b1;
        end
        if (card_bad) begin
          st_nxt.st = cfu_pkg::S_CCC;
          st_nxt.ret = cfu_pkg::S_MON;
        end else if ((st_r.keys_rel && both_keys) || i_sw_start) begin
          st_nxt.st = cfu_pkg::S_COPY;
          st_nxt.cnt = 7'h00;
          st_nxt.bitn = 3'h0;
          st_nxt.card.req = 1'b1;
          st_nxt.card.file = `CFU_FILE_IMG;
          st_nxt.card.sd_mode = s[`CFU_IN_SD];
          st_nxt.disp.mode = cfu_pkg::DISP_NUM;
          st_nxt.disp.value = 7'h00;
        end
      end
      cfu_pkg::S_COPY: begin
        if (card_bad) begin
          st_nxt.st = cfu_pkg::S_CCC;
          st_nxt.ret = cfu_pkg::S_COPY;
          st_nxt.card.req = 1'b0;
        end else if (bit_edge) begin
          st_nxt.shreg = new_byte;
          st_nxt.bitn = st_r.bitn + 3'h1;
          if (st_r.bitn == 3'h7) begin
            st_nxt.mem[st_r.cnt[5:0]] = new_byte;
            st_nxt.cnt = st_r.cnt + 7'h01;
            st_nxt.disp.value = pct(st_r.cnt + 7'h01);
            if (st_r.cnt == `CFU_IMG_LAST) begin
              st_nxt.st = cfu_pkg::S_ERASE;
              st_nxt.card.req = 1'b0;
              st_nxt.card.file = `CFU_FILE_NONE;
              st_nxt.pm.erase = 1'b1;
            end
          end
        end
      end
      cfu_pkg::S_ERASE: begin
        st_nxt.disp.value = `CFU_PCT_TOP;
        if (i_pm_done) begin
          st_nxt.pm.erase = 1'b0;
          st_nxt.st = cfu_pkg::S_PROG;
          st_nxt.cnt = 7'h00;
          st_nxt.busy = 1'b0;
        end
      end
      cfu_pkg::S_PROG: begin
        if (!st_r.busy) begin
          st_nxt.pm.we = 1'b1;
          st_nxt.pm.addr = st_r.cnt[5:0];
          st_nxt.pm.data = st_r.mem[st_r.cnt[5:0]];
          st_nxt.busy = 1'b1;
        end else if (i_pm_done && !st_r.pm.we) begin
          st_nxt.busy = 1'b0;
          st_nxt.cnt = st_r.cnt + 7'h01;
          st_nxt.disp.value = `CFU_PCT_TOP - pct(st_r.cnt + 7'h01);
          if (st_r.cnt == `CFU_IMG_LAST) begin
            st_nxt.fw_run = 1'b1;
            st_nxt.disp.mode = cfu_pkg::DISP_BLANK;
            st_nxt.st = cfu_pkg::S_PAR;
            st_nxt.cnt = 7'h00;
            st_nxt.bitn = 3'h0;
          end
        end
      end
      cfu_pkg::S_PAR: begin
        st_nxt.card.req = 1'b1;
        st_nxt.card.file = `CFU_FILE_PAR;
        if (card_bad || s[`CFU_IN_NOFILE]) begin
          st_nxt.st = cfu_pkg::S_RUN;
          st_nxt.card.req = 1'b0;
          st_nxt.card.file = `CFU_FILE_NONE;
        end else if (bit_edge) begin
          st_nxt.shreg = new_byte;
          st_nxt.bitn = st_r.bitn + 3'h1;
          if (st_r.bitn == 3'h7) begin
            st_nxt.par_stb = 1'b1;
            st_nxt.par_byte = new_byte;
            st_nxt.cnt = st_r.cnt + 7'h01;
            if (st_r.cnt == `CFU_PAR_LAST) begin
              st_nxt.st = cfu_pkg::S_RUN;
              st_nxt.card.req = 1'b0;
              st_nxt.card.file = `CFU_FILE_NONE;
            end
          end
        end
      end
      cfu_pkg::S_RUN: begin
        st_nxt.fw_run = 1'b1;
      end
      cfu_pkg::S_CCC: begin
        st_nxt.disp.mode = cfu_pkg::DISP_CCC;
        if (!card_bad) begin
          st_nxt.st = st_r.ret;
          if (st_r.ret == cfu_pkg::S_COPY) begin
            st_nxt.cnt = 7'h00;
            st_nxt.bitn = 3'h0;
            st_nxt.card.req = 1'b1;
            st_nxt.card.file = `CFU_FILE_IMG;
            st_nxt.disp.mode = cfu_pkg::DISP_NUM;
            st_nxt.disp.value = 7'h00;
          end
        end
      end
      default: st_nxt.st = cfu_pkg::S_POR;
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs straight from the state register
  assign o_disp = st_r.disp;
  assign o_pm = st_r.pm;
  assign o_card = st_r.card;
  assign o_fw_run = st_r.fw_run;
  assign o_par_stb = st_r.par_stb;
  assign o_par_byte = st_r.par_byte;

  // ==========================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_powerup_keys;
    st_r.st == cfu_pkg::S_POR && s[`CFU_IN_AUX] && both_keys;
  endsequence
  sequence s_dash_shown;
    st_r.st == cfu_pkg::S_MON ##1 o_disp.mode == cfu_pkg::DISP_DASH;
  endsequence

  a_mon_entry: assert property (s_powerup_keys |=> s_dash_shown)
    else $error("monitor entry without dash");
  a_ccc_fail: assert property (st_r.st == cfu_pkg::S_MON && card_bad
    |=> ##1 o_disp.mode == cfu_pkg::DISP_CCC)
    else $error("card failure not shown");
  a_copy_resume: assert property (st_r.st == cfu_pkg::S_CCC
    && st_r.ret == cfu_pkg::S_COPY && !card_bad
    |=> st_r.st == cfu_pkg::S_COPY && o_card.req)
    else $error("copy did not resume");
  a_second_press: assert property (st_r.st == cfu_pkg::S_MON && !card_bad
    && st_r.keys_rel && both_keys |=> st_r.st == cfu_pkg::S_COPY)
    else $error("second key press ignored");
  a_copy_up: assert property (st_r.st == cfu_pkg::S_COPY
    && $past(st_r.st) == cfu_pkg::S_COPY
    |-> o_disp.value >= $past(o_disp.value))
    else $error("copy progress went down");
  a_erase_hold: assert property (st_r.st == cfu_pkg::S_ERASE
    |=> o_disp.value == `CFU_PCT_TOP)
    else $error("erase display not at top");
  a_prog_down: assert property (st_r.st == cfu_pkg::S_PROG
    && $past(st_r.st) == cfu_pkg::S_PROG
    |-> o_disp.value <= $past(o_disp.value))
    else $error("program progress went up");
  a_fw_start: assert property (st_r.st == cfu_pkg::S_PROG && st_r.busy
    && !st_r.pm.we && i_pm_done && st_r.cnt == `CFU_IMG_LAST
    |=> o_fw_run && st_r.st == cfu_pkg::S_PAR)
    else $error("firmware not started");
  a_par_skip: assert property (st_r.st == cfu_pkg::S_PAR
    && s[`CFU_IN_NOFILE] |=> st_r.st == cfu_pkg::S_RUN && !o_card.req)
    else $error("missing parameter file not skipped");
  a_copy_full: assert property (st_r.st == cfu_pkg::S_COPY && bit_edge
    && !card_bad && st_r.bitn == 3'h7 && st_r.cnt == `CFU_IMG_LAST
    |=> o_disp.value == `CFU_PCT_TOP ##1 o_pm.erase)
    else $error("copy end not at top");
endmodule

//--- verif/cfu_card_model.sv
// Behavioural memory card that streams the image and parameter files
`timescale 1ns/1ps
`include "cfu_params.svh"
module cfu_card_model (
  input wire logic i_req,
  input wire logic [1:0] i_file,
  input wire logic i_pulled,
  input wire logic i_mmc,
  input wire logic i_nofile,
  output logic o_clk,
  output logic o_dat,
  output logic o_present,
  output logic o_err,
  output logic o_nofile,
  output logic o_sd
);
  int n;
  int b;
  logic [7:0] bv;
  // Presence follows the pull-out control, family and file set by bench
  assign o_present = !i_pulled;
  assign o_err = 1'b0;
  assign o_nofile = i_nofile;
  assign o_sd = !i_mmc;
  // file streaming
  // Clock stands still outside frames, each frame restarts at byte 0
  initial begin
    o_clk = 1'b0;
    o_dat = 1'b0;
    forever begin
      wait (i_req === 1'b1 && !i_pulled);
      // Step off the system clock edge that raised the request
      #10;
      n = 0;
      while (i_req === 1'b1 && !i_pulled) begin
        bv = (i_file == `CFU_FILE_PAR) ? 8'h30 + n[7:0] : 8'hA5 ^ n[7:0];
        for (b = 7; b >= 0 && i_req === 1'b1 && !i_pulled; b--) begin
          o_dat = bv[b];
          #200;
          if (i_req === 1'b1 && !i_pulled) o_clk = 1'b1;
          #200 o_clk = 1'b0;
        end
        n++;
      end
      // Released data line shows the inverse of its last value
      o_dat = ~o_dat;
    end
  end
endmodule

//--- verif/cfu_tb_top.sv
// Self-checking bench of the card firmware update sequencer
`timescale 1ns/1ps
`include "cfu_params.svh"
module cfu_tb_top;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic [6:0] val;
  } cfu_row_t;
  logic i_sys_clk, i_rst_n, i_key_a, i_key_b, i_aux_ok, i_sw_start;
  logic i_pm_done, pulled, mmc, nofile;
  logic c_clk, c_dat, c_pres, c_err, c_nofile, c_sd;
  cfu_pkg::cfu_disp_t o_disp;
  cfu_pkg::cfu_pm_t o_pm;
  cfu_pkg::cfu_card_t o_card;
  logic o_fw_run, o_par_stb;
  logic [7:0] o_par_byte;
  cfu_row_t rows [64];
  logic [6:0] prev;
  int n_errors, samples_checked, k, i, nchg, n_par;
  cfu_top u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_key_a(i_key_a), .i_key_b(i_key_b), .i_aux_ok(i_aux_ok),
    .i_sw_start(i_sw_start), .i_card_present(c_pres), .i_card_err(c_err),
    .i_card_clk(c_clk), .i_card_dat(c_dat), .i_card_nofile(c_nofile),
    .i_card_sd(c_sd), .i_pm_done(i_pm_done), .o_disp(o_disp), .o_pm(o_pm),
    .o_card(o_card), .o_fw_run(o_fw_run), .o_par_stb(o_par_stb),
    .o_par_byte(o_par_byte));
  cfu_card_model u_card (.i_req(o_card.req), .i_file(o_card.file),
    .i_pulled(pulled), .i_mmc(mmc), .i_nofile(nofile), .o_clk(c_clk),
    .o_dat(c_dat), .o_present(c_pres), .o_err(c_err), .o_nofile(c_nofile),
    .o_sd(c_sd));
  // Compare one value and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #1500000;
    n_errors++;
    wrap_up();
  end
  // Parameter bytes arrive in order, sampled mid-cycle
  always @(negedge i_sys_clk) begin
    if (o_par_stb === 1'b1) begin
      chk(o_par_byte, 8'h30 + n_par[7:0]); // byte order
      n_par++;
    end
  end
  // Main sequence
  initial begin
    {i_rst_n, i_sw_start, i_pm_done, pulled} = 4'h0;
    {mmc, nofile} = 2'h0;
    {i_key_a, i_key_b, i_aux_ok} = 3'h7;
    n_errors = 0;
    samples_checked = 0;
    n_par = 0;
    for (i = 0; i < 64; i++) begin
      rows[i] = '{i[5:0], 8'hA5 ^ i[7:0], 7'(100 - (i + 1) * 100 / 64)};
    end
    repeat (2) @(negedge i_sys_clk);
    chk(o_disp.mode, cfu_pkg::DISP_BLANK);
    chk(o_fw_run, 1'b0);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    for (k = 0; k < 20 && o_disp.mode !== cfu_pkg::DISP_DASH; k++)
      @(negedge i_sys_clk);
    chk(o_disp.mode, cfu_pkg::DISP_DASH); // dash in monitor
    chk(o_card.req, 1'b0); // no start before second press
    {i_key_a, i_key_b} = 2'h0;
    repeat (10) @(negedge i_sys_clk);
    {i_key_a, i_key_b} = 2'h3;
    for (k = 0; k < 20 && o_card.req !== 1'b1; k++) @(negedge i_sys_clk);
    chk(o_card.file, `CFU_FILE_IMG); // update starts
    chk(o_disp.value, 7'h00); // count starts at zero
    chk(o_card.sd_mode, 1'b1); // card family seen
    {i_key_a, i_key_b} = 2'h0;
    repeat (1280) @(negedge i_sys_clk);
    pulled = 1'b1;
    for (k = 0; k < 40 && o_disp.mode !== cfu_pkg::DISP_CCC; k++)
      @(negedge i_sys_clk);
    chk(o_disp.mode, cfu_pkg::DISP_CCC); // card failure shown
    chk(o_card.req, 1'b0); // transfer halted
    repeat (20) @(negedge i_sys_clk);
    pulled = 1'b0;
    for (k = 0; k < 40 && o_disp.mode !== cfu_pkg::DISP_NUM; k++)
      @(negedge i_sys_clk);
    chk(o_card.req, 1'b1); // resumes without keys
    chk(o_disp.value, 7'h00); // restart from first byte
    prev = 7'h00;
    nchg = 0;
    for (k = 0; k < 6000 && o_pm.erase !== 1'b1; k++) begin
      @(negedge i_sys_clk);
      if (o_disp.value !== prev) begin
        if (o_disp.value < prev) chk(o_disp.value, prev); // no fall
        prev = o_disp.value;
        nchg++;
      end
    end
    chk(nchg, 64); // one step per byte
    chk(prev, `CFU_PCT_TOP); // ends at top
    repeat (30) @(negedge i_sys_clk);
    chk(o_pm.erase, 1'b1); // erase held
    chk(o_disp.value, `CFU_PCT_TOP); // top during erase
    i_pm_done = 1'b1;
    @(negedge i_sys_clk);
    i_pm_done = 1'b0;
    // Program phase walks through the rows
    for (i = 0; i < 64; i++) begin
      for (k = 0; k < 20 && o_pm.we !== 1'b1; k++) @(negedge i_sys_clk);
      chk(o_pm.addr, rows[i].addr); // address order
      chk(o_pm.data, rows[i].data); // copied byte written
      @(negedge i_sys_clk);
      i_pm_done = 1'b1;
      @(negedge i_sys_clk);
      i_pm_done = 1'b0;
      @(negedge i_sys_clk);
      chk(o_disp.value, rows[i].val); // counts down
    end
    chk(o_fw_run, 1'b1); // new firmware starts
    // no encoder here, homing not needed
    for (k = 0; k < 20 && o_card.req !== 1'b1; k++) @(negedge i_sys_clk);
    chk(o_card.file, `CFU_FILE_PAR); // parameter file read
    for (k = 0; k < 3000 && n_par < 16; k++) @(negedge i_sys_clk);
    repeat (10) @(negedge i_sys_clk);
    chk(n_par, 16); // whole file loaded
    chk(o_card.req, 1'b0); // request released
    // Mid-run reset into the monitor with an MMC card
    i_rst_n = 1'b0;
    mmc = 1'b1;
    {i_key_a, i_key_b} = 2'h3;
    repeat (2) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    @(negedge i_sys_clk);
    chk(o_fw_run, 1'b0); // cleared by reset
    chk(o_card.req, 1'b0); // no request after reset
    chk(o_disp.mode, cfu_pkg::DISP_BLANK); // blank before power-up seen
    for (k = 0; k < 20 && o_disp.mode !== cfu_pkg::DISP_DASH; k++)
      @(negedge i_sys_clk);
    chk(o_disp.mode, cfu_pkg::DISP_DASH); // dash after second reset
    // Card lost while in the monitor
    pulled = 1'b1;
    for (k = 0; k < 40 && o_disp.mode !== cfu_pkg::DISP_CCC; k++)
      @(negedge i_sys_clk);
    chk(o_disp.mode, cfu_pkg::DISP_CCC); // failure in monitor
    pulled = 1'b0;
    for (k = 0; k < 40 && o_disp.mode !== cfu_pkg::DISP_DASH; k++)
      @(negedge i_sys_clk);
    chk(o_disp.mode, cfu_pkg::DISP_DASH); // monitor resumes
    // Update started from the setup software
    i_sw_start = 1'b1;
    @(negedge i_sys_clk);
    i_sw_start = 1'b0;
    @(negedge i_sys_clk);
    chk(o_card.req, 1'b1); // software start
    chk(o_card.sd_mode, 1'b0); // MMC card seen
    // Plain power-up, card without a parameter file
    i_rst_n = 1'b0;
    nofile = 1'b1;
    {i_key_a, i_key_b} = 2'h0;
    repeat (2) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    repeat (12) @(negedge i_sys_clk);
    chk(o_fw_run, 1'b1); // firmware runs without file
    chk(o_card.req, 1'b0); // missing file skipped
    chk(n_par, 16); // nothing more loaded
    wrap_up();
  end
endmodule
